/* mjpeg_framer_pkg.sv */
package mjpeg_framer_pkg;

    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int CNT_W  = 16;
    localparam int HDR_W  = 96;

    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] FRAMES_OFS = 8'h04;
    localparam logic [7:0] SEGLEN_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // Control and status register field positions
    localparam int CTRL_START   = 0;
    localparam int CTRL_HEN     = 1;
    localparam int CTRL_ABS     = 2;
    localparam int CTRL_AMT_LO  = 4;
    localparam int CTRL_POS_LO  = 6;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_ERR     = 1;
    localparam int STAT_CNT_LO  = 16;

    // Descriptor field positions
    localparam int DESC_POS_LO = 30;
    localparam int DESC_AMT_LO = 28;
    localparam int DESC_HEN    = 27;
    localparam int DESC_RSV_W  = 27;

    // Field codes
    localparam logic [1:0] POS_MIDDLE = 2'h0;
    localparam logic [1:0] POS_FIRST  = 2'h1;
    localparam logic [1:0] POS_LAST   = 2'h2;
    localparam logic [1:0] AMT_SEG    = 2'h0;
    localparam logic [1:0] AMT_ONE    = 2'h1;
    localparam logic [1:0] AMT_MULTI  = 2'h2;
    localparam logic [1:0] CODE_RSV   = 2'h3;

    localparam logic [7:0] FILLER_BYTE = 8'h00;
    localparam logic [2:0] DESC_WORDS  = 3'h2;
    localparam logic [2:0] HDR_WORDS   = 3'h6;

    // Reset values
    localparam logic [CNT_W-1:0] FRAMES_RST = 16'h0002;
    localparam logic [CNT_W-1:0] SEGLEN_RST = 16'h0100;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DESC = 3'b001,
        ST_HDR  = 3'b011,
        ST_DATA = 3'b010
    } framer_state_t;

endpackage : mjpeg_framer_pkg

/* word_skid_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
module word_skid_buffer #(
    parameter int WIDTH = 17
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output var  logic             in_ready_out,
    output var  logic             out_valid_out,
    output var  logic [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    logic             skid_valid;
    logic [WIDTH-1:0] skid_data;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             next_skid_valid;
    logic [WIDTH-1:0] next_skid_data;
    logic             take;

    // Two entries: output register plus one skid slot, so ready stays a flop
    always_comb begin
        take            = in_valid_in && in_ready_out;
        next_out_valid  = out_valid_out;
        next_out_data   = out_data_out;
        next_skid_valid = skid_valid;
        next_skid_data  = skid_data;
        if (out_ready_in || !out_valid_out) begin
            if (skid_valid) begin
                next_out_valid  = 1'b1;
                next_out_data   = skid_data;
                next_skid_valid = take;
                next_skid_data  = in_data_in;
            end else begin
                next_out_valid = take;
                next_out_data  = in_data_in;
            end
        end else if (take) begin
            next_skid_valid = 1'b1;
            next_skid_data  = in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
            skid_valid    <= 1'b0;
            skid_data     <= '0;
            in_ready_out  <= 1'b0;
        end else begin
            out_valid_out <= next_out_valid;
            out_data_out  <= next_out_data;
            skid_valid    <= next_skid_valid;
            skid_data     <= next_skid_data;
            in_ready_out  <= !next_skid_valid;
        end
    end
endmodule // word_skid_buffer
`default_nettype wire

/* mjpeg_video_packet_framer.sv */
`timescale 1ns/100ps
`default_nettype none
module mjpeg_video_packet_framer (
    input  wire logic                                      clk_in,
    input  wire logic                                      arst_n_in,
    input  wire logic                                      psel_in,
    input  wire logic                                      penable_in,
    input  wire logic                                      pwrite_in,
    input  wire logic [7:0]                                paddr_in,
    input  wire logic [31:0]                               pwdata_in,
    output var  logic [31:0]                               prdata_out,
    output var  logic                                      pready_out,
    output var  logic                                      pslverr_out,
    input  wire logic                                      src_valid_in,
    input  wire logic [mjpeg_framer_pkg::BYTE_W-1:0]       src_data_in,
    input  wire logic                                      src_last_in,
    input  wire logic [63:0]                               src_time_in,
    input  wire logic [31:0]                               src_len_in,
    output var  logic                                      src_ready_out,
    output var  logic                                      pkt_valid_out,
    output var  logic [mjpeg_framer_pkg::WORD_W-1:0]       pkt_data_out,
    output var  logic                                      pkt_last_out,
    input  wire logic                                      pkt_ready_in
);
    import mjpeg_framer_pkg::*;

    // Register file
    logic             hdr_en;
    logic             abs_time;
    logic [1:0]       amount;
    logic [1:0]       position;
    logic [CNT_W-1:0] frames_cfg;
    logic [CNT_W-1:0] seg_len;
    logic             cfg_err;
    logic [15:0]      pkt_count;
    logic             next_pready;
    logic [31:0]      next_prdata;
    logic             next_pslverr;
    logic             next_hdr_en;
    logic             next_abs_time;
    logic [1:0]       next_amount;
    logic [1:0]       next_position;
    logic [CNT_W-1:0] next_frames_cfg;
    logic [CNT_W-1:0] next_seg_len;
    logic             next_cfg_err;
    logic [15:0]      next_pkt_count;
    logic             start;
    logic             bus_done;
    logic             mapped;

    // Framer state
    framer_state_t    state;
    framer_state_t    next_state;
    logic [2:0]       idx;
    logic [2:0]       next_idx;
    logic [HDR_W-1:0] hdr;
    logic [HDR_W-1:0] next_hdr;
    logic             phase;
    logic             next_phase;
    logic [7:0]       low_byte;
    logic [7:0]       next_low_byte;
    logic [CNT_W-1:0] seg_cnt;
    logic [CNT_W-1:0] next_seg_cnt;
    logic [CNT_W-1:0] frames_left;
    logic [CNT_W-1:0] next_frames_left;
    logic             word_valid;
    logic [WORD_W:0]  word;
    logic             next_word_valid;
    logic [WORD_W:0]  next_word;
    logic             next_src_ready;
    logic             buf_ready;
    logic             slot_free;
    logic             byte_take;
    logic             unit_end;
    logic             last_unit;
    logic             packet_end;
    logic [31:0]      desc;
    logic [31:0]      time_high;
    logic             cfg_bad;

    function automatic logic need_header(input logic en, input logic [1:0] amt,
                                         input logic [1:0] pos);
        need_header = en && (amt != AMT_SEG || pos == POS_FIRST);
    endfunction

    // Descriptor: reserved tail forced low, position only for segments
    always_comb begin
        desc = '0;
        desc[DESC_POS_LO +: 2] = (amount == AMT_SEG) ? position : POS_MIDDLE;
        desc[DESC_AMT_LO +: 2] = amount;
        desc[DESC_HEN]         = hdr_en;
    end

    // Reserved codes, a frame count below 2 for multi and an empty segment length are refused at start
    assign cfg_bad = (next_amount == CODE_RSV) || (next_position == CODE_RSV)
                  || (next_amount == AMT_MULTI && frames_cfg < 16'h0002)
                  || (next_amount == AMT_SEG && seg_len == '0);

    // APB slave, one wait state; writes land on the edge that sees pready
    assign bus_done = psel_in && penable_in && pready_out;
    assign mapped   = (paddr_in == CTRL_OFS) || (paddr_in == FRAMES_OFS)
                   || (paddr_in == SEGLEN_OFS) || (paddr_in == STATUS_OFS);

    always_comb begin
        next_pready     = psel_in && penable_in && !pready_out;
        next_prdata     = prdata_out;
        next_pslverr    = 1'b0;
        next_hdr_en     = hdr_en;
        next_abs_time   = abs_time;
        next_amount     = amount;
        next_position   = position;
        next_frames_cfg = frames_cfg;
        next_seg_len    = seg_len;
        next_pkt_count  = pkt_count;
        start           = 1'b0;
        if (next_pready) begin
            next_pslverr = !mapped;
            next_prdata  = '0;
            if (!pwrite_in) begin
                unique case (paddr_in)
                    CTRL_OFS: begin
                        next_prdata[CTRL_HEN]         = hdr_en;
                        next_prdata[CTRL_ABS]         = abs_time;
                        next_prdata[CTRL_AMT_LO +: 2] = amount;
                        next_prdata[CTRL_POS_LO +: 2] = position;
                    end
                    FRAMES_OFS: next_prdata[CNT_W-1:0] = frames_cfg;
                    SEGLEN_OFS: next_prdata[CNT_W-1:0] = seg_len;
                    STATUS_OFS: begin
                        next_prdata[STAT_BUSY]         = (state != ST_IDLE);
                        next_prdata[STAT_ERR]          = cfg_err;
                        next_prdata[STAT_CNT_LO +: 16] = pkt_count;
                    end
                    default: next_prdata = '0;
                endcase
            end
        end
        // Configuration is frozen while a packet is being built
        if (bus_done && pwrite_in && state == ST_IDLE) begin
            if (paddr_in == CTRL_OFS) begin
                next_hdr_en   = pwdata_in[CTRL_HEN];
                next_abs_time = pwdata_in[CTRL_ABS];
                next_amount   = pwdata_in[CTRL_AMT_LO +: 2];
                next_position = pwdata_in[CTRL_POS_LO +: 2];
                start         = pwdata_in[CTRL_START];
            end
            if (paddr_in == FRAMES_OFS) begin
                next_frames_cfg = pwdata_in[CNT_W-1:0];
            end
            if (paddr_in == SEGLEN_OFS) begin
                next_seg_len = pwdata_in[CNT_W-1:0];
            end
        end
        if (packet_end) begin
            next_pkt_count = pkt_count + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
            hdr_en      <= 1'b0;
            abs_time    <= 1'b0;
            amount      <= AMT_ONE;
            position    <= POS_MIDDLE;
            frames_cfg  <= FRAMES_RST;
            seg_len     <= SEGLEN_RST;
            pkt_count   <= '0;
        end else begin
            pready_out  <= next_pready;
            prdata_out  <= next_prdata;
            pslverr_out <= next_pslverr;
            hdr_en      <= next_hdr_en;
            abs_time    <= next_abs_time;
            amount      <= next_amount;
            position    <= next_position;
            frames_cfg  <= next_frames_cfg;
            seg_len     <= next_seg_len;
            pkt_count   <= next_pkt_count;
        end
    end

    // Packet sequencer
    assign slot_free = !word_valid || buf_ready;
    assign byte_take = src_valid_in && src_ready_out;
    assign unit_end  = src_last_in
                    || (amount == AMT_SEG && seg_cnt + 16'h0001 == seg_len);
    assign last_unit = (frames_left == 16'h0001);
    assign packet_end = byte_take && unit_end && last_unit;

    always_comb begin
        time_high = src_time_in[63:32];
        if (!abs_time) begin
            time_high[31:16] = 16'h0000;
        end
    end

    always_comb begin
        next_state       = state;
        next_idx         = idx;
        next_hdr         = hdr;
        next_phase       = phase;
        next_low_byte    = low_byte;
        next_seg_cnt     = seg_cnt;
        next_frames_left = frames_left;
        next_cfg_err     = cfg_err;
        next_word_valid  = word_valid && !buf_ready;
        next_word        = word;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_cfg_err = cfg_bad;
                    if (!cfg_bad) begin
                        next_state       = ST_DESC;
                        next_idx         = '0;
                        next_frames_left = (next_amount == AMT_MULTI) ? frames_cfg : 16'h0001;
                    end
                end
            end
            ST_DESC: begin
                if (slot_free) begin
                    next_word_valid = 1'b1;
                    next_word       = {1'b0, desc[idx[0]*WORD_W +: WORD_W]};
                    next_idx        = idx + 3'h1;
                    if (idx + 3'h1 == DESC_WORDS) begin
                        next_idx     = '0;
                        next_phase   = 1'b0;
                        next_seg_cnt = '0;
                        next_state   = need_header(hdr_en, amount, position)
                                       ? ST_HDR : ST_DATA;
                    end
                end
            end
            ST_HDR: begin
                if (idx == '0) begin
                    // Stamp and length travel with the frame's first byte
                    if (src_valid_in) begin
                        next_hdr = {src_len_in, time_high, src_time_in[31:0]};
                        next_idx = 3'h1;
                    end
                end else if (slot_free) begin
                    next_word_valid = 1'b1;
                    next_word = {1'b0, hdr[(idx - 3'h1)*WORD_W +: WORD_W]};
                    next_idx  = idx + 3'h1;
                    if (idx == HDR_WORDS) begin
                        next_idx   = '0;
                        next_state = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (byte_take) begin
                    next_seg_cnt = seg_cnt + 16'h0001;
                    if (phase) begin
                        next_word_valid = 1'b1;
                        next_word       = {packet_end, src_data_in, low_byte};
                        next_phase      = 1'b0;
                    end else if (unit_end) begin
                        next_word_valid = 1'b1;
                        next_word       = {packet_end, FILLER_BYTE, src_data_in};
                    end else begin
                        next_low_byte = src_data_in;
                        next_phase    = 1'b1;
                    end
                    if (unit_end) begin
                        next_phase       = 1'b0;
                        next_seg_cnt     = '0;
                        next_frames_left = frames_left - 16'h0001;
                        if (last_unit) begin
                            next_state = ST_IDLE;
                        end else if (need_header(hdr_en, amount, position)) begin
                            next_state = ST_HDR;
                        end
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // A taken byte must always find the word slot empty
        next_src_ready = (next_state == ST_DATA) && !next_word_valid;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state         <= ST_IDLE;
            idx           <= '0;
            hdr           <= '0;
            phase         <= 1'b0;
            low_byte      <= '0;
            seg_cnt       <= '0;
            frames_left   <= '0;
            cfg_err       <= 1'b0;
            word_valid    <= 1'b0;
            word          <= '0;
            src_ready_out <= 1'b0;
        end else begin
            state         <= next_state;
            idx           <= next_idx;
            hdr           <= next_hdr;
            phase         <= next_phase;
            low_byte      <= next_low_byte;
            seg_cnt       <= next_seg_cnt;
            frames_left   <= next_frames_left;
            cfg_err       <= next_cfg_err;
            word_valid    <= next_word_valid;
            word          <= next_word;
            src_ready_out <= next_src_ready;
        end
    end

    // Receiver stall is absorbed here and pushed back to the source
    word_skid_buffer #(
        .WIDTH (WORD_W + 1)
    ) u_out_buffer (
        .clk_in        (clk_in),
        .arst_n_in     (arst_n_in),
        .in_valid_in   (word_valid),
        .in_data_in    (word),
        .in_ready_out  (buf_ready),
        .out_valid_out (pkt_valid_out),
        .out_data_out  ({pkt_last_out, pkt_data_out}),
        .out_ready_in  (pkt_ready_in)
    );

endmodule // mjpeg_video_packet_framer
`default_nettype wire

/* mjpeg_framer_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module mjpeg_framer_chk (
    input wire logic        clk_in,
    input wire logic        arst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        src_valid_in,
    input wire logic [7:0]  src_data_in,
    input wire logic        src_last_in,
    input wire logic [63:0] src_time_in,
    input wire logic [31:0] src_len_in,
    input wire logic        src_ready_out,
    input wire logic        pkt_valid_out,
    input wire logic [15:0] pkt_data_out,
    input wire logic        pkt_last_out,
    input wire logic        pkt_ready_in
);
    import mjpeg_framer_pkg::*;
    logic [3:0] idx;
    logic [3:0] next_idx;
    logic       abs_q;
    logic       next_abs;
    logic       hdr_q;
    logic       next_hdr;
    wire        acc = pkt_valid_out && pkt_ready_in;
    always_comb begin
        next_idx = idx;
        next_abs = abs_q;
        next_hdr = hdr_q;
        if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == CTRL_OFS)
            next_abs = pwdata_in[CTRL_ABS];
        if (acc && idx == 4'h1)
            next_hdr = pkt_data_out[11] && (pkt_data_out[13:12] != 2'h0 || pkt_data_out[15:14] == 2'h1);
        if (acc)
            next_idx = pkt_last_out ? 4'h0 : idx + {3'h0, idx != 4'hf};
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            idx   <= 4'h0;
            abs_q <= 1'b0;
            hdr_q <= 1'b0;
        end else begin
            idx   <= next_idx;
            abs_q <= next_abs;
            hdr_q <= next_hdr;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_stall; pkt_valid_out && !pkt_ready_in; endsequence
    sequence s_access; psel_in && penable_in && !pready_out; endsequence
    chk_word_hold: assert property (s_stall |=> pkt_valid_out && $stable(pkt_data_out) && $stable(pkt_last_out))
        else $error("output word changed while stalled");
    chk_apb_answer: assert property (s_access |=> pready_out)
        else $error("no answer after access cycle");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    chk_err_unmapped: assert property (pready_out |->
        pslverr_out == (paddr_in > STATUS_OFS || paddr_in[1:0] != 2'h0))
        else $error("error response wrong");
    chk_desc_low: assert property (acc && idx == 4'h0 |-> pkt_data_out == 16'h0)
        else $error("descriptor low half not zero");
    chk_desc_rsv: assert property (acc && idx == 4'h1 |-> pkt_data_out[10:0] == 11'h0)
        else $error("descriptor reserved bits set");
    chk_desc_codes: assert property (acc && idx == 4'h1 |-> pkt_data_out[15:14] != CODE_RSV && pkt_data_out[13:12] != CODE_RSV)
        else $error("reserved code emitted");
    chk_pos_whole: assert property (acc && idx == 4'h1 && pkt_data_out[13:12] != AMT_SEG |-> pkt_data_out[15:14] == POS_MIDDLE)
        else $error("position set for whole frames");
    chk_no_early_last: assert property (acc && idx < 4'h2 |-> !pkt_last_out)
        else $error("packet ended inside descriptor");
    chk_time_high: assert property (acc && idx == 4'h5 && hdr_q && !abs_q |-> pkt_data_out == 16'h0)
        else $error("relative stamp top bits not zero");
endmodule // mjpeg_framer_chk
`default_nettype wire

/* video_stream_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module video_stream_partner (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        go_in,
    input  wire logic        stall_in,
    input  wire logic [15:0] len_in,
    input  wire logic [63:0] time_in,
    input  wire logic [7:0]  base_in,
    input  wire logic        src_ready_in,
    output var  logic        src_valid_out,
    output var  logic [7:0]  src_data_out,
    output var  logic        src_last_out,
    output var  logic [63:0] src_time_out,
    output var  logic [31:0] src_len_out,
    output var  logic        pkt_ready_out,
    output var  logic        busy_out
);
    logic [15:0] idx;
    logic [7:0]  base;
    logic [15:0] len;
    initial {src_valid_out, src_data_out, src_last_out, pkt_ready_out, busy_out} = '0;
    initial {src_time_out, src_len_out} = '0;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            src_valid_out <= 1'b0;
            src_last_out  <= 1'b0;
            pkt_ready_out <= 1'b0;
            busy_out      <= 1'b0;
        end else begin
            // Sink stalls about one cycle in three when asked
            pkt_ready_out <= !stall_in || ($urandom % 3 != 0);
            if (go_in) begin
                idx           <= 16'h0;
                base          <= base_in;
                len           <= len_in;
                src_valid_out <= 1'b1;
                src_data_out  <= base_in;
                src_last_out  <= len_in == 16'h1;
                src_time_out  <= time_in;
                src_len_out   <= {16'h0, len_in};
                busy_out      <= 1'b1;
            end else if (src_valid_out && src_ready_in) begin
                idx          <= idx + 16'h1;
                src_data_out <= base + idx[7:0] + 8'h1;
                src_last_out <= idx + 16'h2 == len;
                if (src_last_out) begin
                    src_valid_out <= 1'b0;
                    busy_out      <= 1'b0;
                end
            end else if (!src_valid_out)
                // Released line toggles so no stale byte looks valid
                src_data_out <= ~src_data_out;
        end
    end
endmodule // video_stream_partner
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mjpeg_framer_pkg::*;
    localparam logic [31:0] RV [5] = '{32'h10, 32'h2, 32'h100, 32'h0, 32'h0};
    localparam logic [31:0] BAD [4] = '{32'h31, 32'hc1, 32'h21, 32'h01};
    logic        clk_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic        pready_out, pslverr_out, src_ready_out, pkt_valid_out, pkt_last_out, err;
    logic        src_valid_in, src_last_in, pkt_ready_in, busy, go = 0, stall = 0;
    logic [7:0]  paddr_in = 0, src_data_in, fbase = 0;
    logic [15:0] pkt_data_out, flen = 0;
    logic [16:0] exp_q [$];
    logic [31:0] pwdata_in = 0, prdata_out, src_len_in, rd;
    logic [63:0] src_time_in, ftime = 0;
    int          n_fail = 0, n_checks = 0;
    always #5 clk_in = ~clk_in;
    mjpeg_video_packet_framer dut_u (.*);
    video_stream_partner partner_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go),
        .stall_in(stall), .len_in(flen), .time_in(ftime), .base_in(fbase),
        .src_ready_in(src_ready_out), .src_valid_out(src_valid_in), .src_data_out(src_data_in),
        .src_last_out(src_last_in), .src_time_out(src_time_in), .src_len_out(src_len_in),
        .pkt_ready_out(pkt_ready_in), .busy_out(busy));
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task complete_run;
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask
    task exp_desc(input logic [1:0] pos, input logic [1:0] amt, input logic hdr);
        logic [31:0] d;
        d = {pos, amt, hdr, 27'h0};
        exp_q.push_back({1'b0, d[15:0]});
        exp_q.push_back({1'b0, d[31:16]});
    endtask
    task exp_bytes(input logic [7:0] b, input int from, input int n, input logic mark);
        logic [7:0] lo;
        for (int i = 0; i < n; i += 2) begin
            lo = b + 8'(from + i);
            exp_q.push_back({mark && i + 2 >= n, (i + 1 < n) ? lo + 8'h1 : FILLER_BYTE, lo});
        end
    endtask
    task frame(input int n, input logic hdr, input logic ab, input logic mark, input int cnt);
        logic [95:0] h;
        int k;
        ftime = {$urandom, $urandom};
        fbase = 8'($urandom);
        h = {n, ab ? ftime[63:32] : {16'h0, ftime[47:32]}, ftime[31:0]};
        for (k = 0; k < 6 && hdr; k++)
            exp_q.push_back({1'b0, h[16*k +: 16]});
        exp_bytes(fbase, 0, cnt, mark);
        flen <= 16'(n);
        @(posedge clk_in);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        do @(negedge clk_in); while (cnt == n && busy !== 1'b0);
    endtask
    task drain;
        int k;
        k = 0;
        while (exp_q.size() != 0 && k++ < 3000)
            @(negedge clk_in);
        check(exp_q.size(), 0);
        exp_q.delete();
        repeat (4) @(posedge clk_in);
    endtask
    always @(negedge clk_in)
        if (pkt_valid_out === 1'b1 && pkt_ready_in === 1'b1)
            if (exp_q.size() == 0)
                check({15'h0, pkt_last_out, pkt_data_out}, 32'h1_ffff);
            else
                check({15'h0, pkt_last_out, pkt_data_out}, {15'h0, exp_q.pop_front()});
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        complete_run;
    end
    initial begin
        void'($urandom(92338));
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, RV[i]);
            check({31'h0, err}, {31'h0, i == 4});
        end
        apb(1'b1, FRAMES_OFS, 32'h1);
        apb(1'b1, SEGLEN_OFS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, CTRL_OFS, BAD[i]);
            apb(1'b0, STATUS_OFS, 32'h0);
            check({30'h0, rd[1:0]}, 32'h2);
        end
        exp_desc(POS_MIDDLE, AMT_ONE, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h13);
        frame(5, 1'b1, 1'b0, 1'b1, 5);
        drain;
        exp_desc(POS_MIDDLE, AMT_ONE, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h11);
        frame(2, 1'b0, 1'b0, 1'b1, 2);
        drain;
        stall <= 1'b1;
        apb(1'b1, FRAMES_OFS, 32'h3);
        exp_desc(POS_MIDDLE, AMT_MULTI, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h27);
        frame(4, 1'b1, 1'b1, 1'b0, 4);
        frame(1, 1'b1, 1'b1, 1'b0, 1);
        frame(3, 1'b1, 1'b1, 1'b1, 3);
        drain;
        apb(1'b1, SEGLEN_OFS, 32'h4);
        exp_desc(POS_FIRST, AMT_SEG, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h43);
        frame(10, 1'b1, 1'b0, 1'b1, 4);
        drain;
        exp_desc(POS_MIDDLE, AMT_SEG, 1'b1);
        exp_bytes(fbase, 4, 4, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h03);
        drain;
        exp_desc(POS_LAST, AMT_SEG, 1'b1);
        exp_bytes(fbase, 8, 2, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h83);
        drain;
        stall <= 1'b0;
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd, 32'h0006_0000);
        complete_run;
    end
endmodule // testbench
bind mjpeg_video_packet_framer mjpeg_framer_chk chk_u (.*);
`default_nettype wire
